// ===== src/sacw_pkg.sv
// shared constants for the auxiliary configuration word block
package sacw_pkg;
  // serial word layout
  localparam int unsigned WORD_W      = 24;
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned DATA_W      = 20;
  localparam int unsigned FRAC_LO_W   = 12;
  localparam int unsigned FRAC_EXT_W  = 10;
  localparam int unsigned FRAC_W      = 22;
  // address codes in the four lowest bits
  localparam logic [3:0] ADDR_MAIN    = 4'h0;
  localparam logic [3:0] ADDR_THIRD   = 4'h7;
  localparam logic [3:0] ADDR_LMUX    = 4'h9;
  localparam logic [3:0] ADDR_FEXT    = 4'hB;
  // field positions in the lock/mux/modulator word
  localparam int unsigned AUTO_PU_BIT = 23;
  localparam int unsigned DITHER_LSB  = 16;
  localparam int unsigned MORD_LSB    = 14;
  localparam int unsigned DBL_BIT     = 12;
  localparam int unsigned RBUF_BIT    = 11;
  localparam int unsigned APOL_BIT    = 10;
  localparam int unsigned MPOL_BIT    = 9;
  localparam int unsigned PRESC_BIT   = 8;
  localparam int unsigned MUX_LSB     = 4;
  // field positions in the extension word and the third word
  localparam int unsigned EXT_DEN_LSB = 14;
  localparam int unsigned EXT_NUM_LSB = 4;
  localparam int unsigned ACC_EXT_BIT = 21;
  // reset contents of the two words
  localparam logic [23:0] LMUX_RESET  = 24'h02_C709;
  localparam logic [23:0] FEXT_RESET  = 24'h00_000B;
  // modulator order encodings
  localparam logic [1:0] MORD_FOURTH  = 2'h0;
  localparam logic [1:0] MORD_OFF     = 2'h1;
  localparam logic [1:0] MORD_SECOND  = 2'h2;
  localparam logic [1:0] MORD_THIRD   = 2'h3;
endpackage

// ===== src/sacw_half_div.sv
`timescale 1ns/10ps
// divide-by-two toggle on a pulse from one of the loop dividers
module sacw_half_div (
  input  wire logic ref_clk,   // system clock
  input  wire logic rst_n,     // synchronous reset, active low
  input  wire logic div_pulse, // one-cycle pulse per divider output edge
  output logic      half_out   // halved divider output
);
  // toggle each pulse so the pin shows half the divider rate
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      half_out <= 1'b0;
    end else if (div_pulse) begin
      half_out <= ~half_out;
    end
  end

  property p_half_toggle;
    @(posedge ref_clk) disable iff (!rst_n) div_pulse |=> half_out != $past(half_out);
  endproperty
  a_half_toggle: assert property (p_half_toggle)
    else $error("halved output missed a divider pulse");

  property p_half_hold;
    @(posedge ref_clk) disable iff (!rst_n) !div_pulse |=> $stable(half_out);
  endproperty
  a_half_hold: assert property (p_half_hold)
    else $error("halved output moved without a divider pulse");
endmodule

// ===== src/sacw_config_words.sv
`timescale 1ns/10ps
// auxiliary configuration words: mux, polarities, modulator, fraction extension
// How it works
// - mux codes 0,1,2 give high impedance, constant high, constant low.
// - codes 3,4,5 drive combined, main-only, aux-only digital lock.
// - codes 6-8 analog lock open drain; 9-11 same push-pull.
// - codes 12-15 drive aux R, aux N, main R, main N halved.
// - aux prescaler bit picks 8/9 when clear, 16/17 when set.
// - main pump polarity 0 negative, 1 positive; positive by default.
// - aux pump polarity 0 negative, 1 positive; host normally writes 1.
// - reference buffer bit 0 floats reference output, 1 buffers input.
// - doubler bit 1 gives main reference counter twice the input.
// - order code 0 fourth, 2 second, 3 third order modulator.
// - order code 1 disables the modulator; host uses it for test only.
// - dither 0 none, 1 weak, 2 strong, 3 reserved.
// - auto power-up set: main word write clears both power-down bits.
// - chip enable low suppresses auto power-up on main word writes.
// - extension bit 0: numerator 12 bits, upper ten bits ignored.
// - extension bit 1: numerator is ten upper bits over twelve low.
// - access bit clear forces extension word to its default contents.
// - extension word defaults to zero upper numerator and denominator.
module sacw_config_words (
  input  wire logic        ref_clk,            // 20 MHz system clock
  input  wire logic        rst_n,              // synchronous reset, active low
  input  wire logic [23:0] word_data,          // completed serial word
  input  wire logic        word_done,          // one-cycle pulse: transfer complete
  input  wire logic        chip_enable,        // chip enable pin level
  input  wire logic        pd_main_write,      // host power-down write strobe
  input  wire logic        pd_main_value,      // value for main power-down
  input  wire logic        pd_aux_value,       // value for aux power-down
  input  wire logic [11:0] frac_num_low,       // low twelve numerator bits
  input  wire logic [11:0] frac_den_low,       // low twelve denominator bits
  input  wire logic        lock_dig_main,      // main loop digital lock
  input  wire logic        lock_dig_aux,       // aux loop digital lock
  input  wire logic        lock_ana_main,      // main loop analog lock
  input  wire logic        lock_ana_aux,       // aux loop analog lock
  input  wire logic        aux_ref_div_pulse,  // aux reference divider pulse
  input  wire logic        aux_fb_div_pulse,   // aux feedback divider pulse
  input  wire logic        main_ref_div_pulse, // main reference divider pulse
  input  wire logic        main_fb_div_pulse,  // main feedback divider pulse
  input  wire logic        reference_input,    // reference input level
  output logic             test_lock_out,      // test/lock pin output value
  output logic             test_lock_oe_n,     // test/lock pin enable, low drives
  output logic             reference_out,      // reference output pin value
  output logic             reference_oe_n,     // reference pin enable, low drives
  output logic             aux_presc_16,       // 1: 16/17 aux prescaler, 0: 8/9
  output logic             main_pump_polarity, // 1 positive, 0 negative
  output logic             aux_pump_polarity,  // 1 positive, 0 negative
  output logic             ref_doubler_enable, // main reference counter doubled
  output logic             modulator_enable,   // delta-sigma modulator running
  output logic [1:0]       modulator_order,    // raw order code
  output logic [1:0]       dither_select,      // 0 none, 1 weak, 2 strong
  output logic             main_loop_power_down, // main loop powered down
  output logic             aux_loop_power_down,  // aux loop powered down
  output logic [21:0]      fraction_numerator,   // effective numerator
  output logic [21:0]      fraction_denominator, // effective denominator
  output logic             ext_fraction_mode     // 1: 22-bit fraction
);
  logic [23:0] lock_mux_modulator_control; // latched mux/modulator word
  logic [23:0] fraction_extension_word;    // latched extension word
  logic        ext_access;                 // access bit from third word
  logic [3:0]  test_output_select;
  logic [3:0]  word_addr;
  logic [3:0]  half_vec;
  logic [3:0]  pulse_vec;
  logic        next_pin_val;
  logic        next_pin_oe_n;
  logic        auto_power_up;

  assign word_addr = word_data[3:0];
  assign test_output_select = lock_mux_modulator_control[sacw_pkg::MUX_LSB +: 4];
  assign auto_power_up = lock_mux_modulator_control[sacw_pkg::AUTO_PU_BIT];

  // address routing
  // words latch only on the completion pulse so a half-shifted word never leaks
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lock_mux_modulator_control <= sacw_pkg::LMUX_RESET;
    end else if (word_done && word_addr == sacw_pkg::ADDR_LMUX) begin
      lock_mux_modulator_control <= word_data;
    end
  end

  property p_route_lmux;
    @(posedge ref_clk) disable iff (!rst_n)
      word_done && word_addr == sacw_pkg::ADDR_LMUX |=> lock_mux_modulator_control == $past(word_data);
  endproperty
  a_route_lmux: assert property (p_route_lmux)
    else $error("mux word did not take the completed word");

  // access gating
  // clearing the access bit forces the extension word back to its default
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fraction_extension_word <= sacw_pkg::FEXT_RESET;
    end else if (!ext_access) begin
      fraction_extension_word <= sacw_pkg::FEXT_RESET;
    end else if (word_done && word_addr == sacw_pkg::ADDR_FEXT) begin
      fraction_extension_word <= word_data;
    end
  end

  // access bit tracked from the third word
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ext_access <= 1'b0;
    end else if (word_done && word_addr == sacw_pkg::ADDR_THIRD) begin
      ext_access <= word_data[sacw_pkg::ACC_EXT_BIT];
    end
  end

  // auto power-up on main word write
  // chip enable low blocks it; a host write in the same cycle loses
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      main_loop_power_down <= 1'b1;
      aux_loop_power_down  <= 1'b1;
    end else if (word_done && word_addr == sacw_pkg::ADDR_MAIN && auto_power_up && chip_enable) begin
      main_loop_power_down <= 1'b0;
      aux_loop_power_down  <= 1'b0;
    end else if (pd_main_write) begin
      main_loop_power_down <= pd_main_value;
      aux_loop_power_down  <= pd_aux_value;
    end
  end

  property p_auto_power_up;
    @(posedge ref_clk) disable iff (!rst_n)
      word_done && word_addr == sacw_pkg::ADDR_MAIN && auto_power_up && chip_enable |=>
      !main_loop_power_down && !aux_loop_power_down;
  endproperty
  a_auto_power_up: assert property (p_auto_power_up)
    else $error("power-down left set after main word write");

  property p_ce_blocks;
    @(posedge ref_clk) disable iff (!rst_n)
      word_done && word_addr == sacw_pkg::ADDR_MAIN && !chip_enable && !pd_main_write |=>
      $stable(main_loop_power_down) && $stable(aux_loop_power_down);
  endproperty
  a_ce_blocks: assert property (p_ce_blocks)
    else $error("power-down changed while chip enable low");

  // divided-by-two divider outputs, one toggle per divider
  assign pulse_vec = {main_fb_div_pulse, main_ref_div_pulse, aux_fb_div_pulse, aux_ref_div_pulse};
  generate
    for (genvar i = 0; i < 4; i++) begin : g_half
      sacw_half_div u_half (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .div_pulse (pulse_vec[i]),
        .half_out  (half_vec[i])
      );
    end
  endgenerate

  // output multiplexer for the test/lock pin
  always_comb begin
    next_pin_val  = 1'b0;
    next_pin_oe_n = 1'b0;
    unique case (test_output_select)
      4'h0: begin
        next_pin_oe_n = 1'b1;
      end
      4'h1: next_pin_val = 1'b1;
      4'h2: next_pin_val = 1'b0;
      4'h3: next_pin_val = lock_dig_main & lock_dig_aux;
      4'h4: next_pin_val = lock_dig_main;
      4'h5: next_pin_val = lock_dig_aux;
      // analog lock open drain: drive low only, release for high
      4'h6: next_pin_oe_n = lock_ana_main & lock_ana_aux;
      4'h7: next_pin_oe_n = lock_ana_main;
      4'h8: next_pin_oe_n = lock_ana_aux;
      4'h9: next_pin_val = lock_ana_main & lock_ana_aux;
      4'hA: next_pin_val = lock_ana_main;
      4'hB: next_pin_val = lock_ana_aux;
      4'hC: next_pin_val = half_vec[0];
      4'hD: next_pin_val = half_vec[1];
      4'hE: next_pin_val = half_vec[2];
      4'hF: next_pin_val = half_vec[3];
    endcase
  end

  // pin outputs registered so the mux change never glitches the pad
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      test_lock_out  <= 1'b0;
      test_lock_oe_n <= 1'b1;
    end else begin
      test_lock_out  <= next_pin_val;
      test_lock_oe_n <= next_pin_oe_n;
    end
  end

  property p_mux_hiz;
    @(posedge ref_clk) disable iff (!rst_n) test_output_select == 4'h0 |=> test_lock_oe_n;
  endproperty
  a_mux_hiz: assert property (p_mux_hiz)
    else $error("test pin driven while disabled");

  property p_mux_fixed;
    @(posedge ref_clk) disable iff (!rst_n) test_output_select inside {4'h1, 4'h2} |=>
      !test_lock_oe_n && test_lock_out == $past(test_output_select == 4'h1);
  endproperty
  a_mux_fixed: assert property (p_mux_fixed)
    else $error("fixed level wrong on test pin");

  property p_dig_both;
    @(posedge ref_clk) disable iff (!rst_n) test_output_select == 4'h3 |=>
      !test_lock_oe_n && test_lock_out == $past(lock_dig_main & lock_dig_aux);
  endproperty
  a_dig_both: assert property (p_dig_both)
    else $error("combined digital lock wrong on test pin");

  property p_dig_single;
    @(posedge ref_clk) disable iff (!rst_n) test_output_select inside {4'h4, 4'h5} |=>
      !test_lock_oe_n && test_lock_out == $past(test_output_select == 4'h4 ? lock_dig_main : lock_dig_aux);
  endproperty
  a_dig_single: assert property (p_dig_single)
    else $error("single loop digital lock wrong on test pin");

  property p_ana_open_drain;
    @(posedge ref_clk) disable iff (!rst_n) test_output_select == 4'h6 |=>
      !test_lock_out && test_lock_oe_n == $past(lock_ana_main & lock_ana_aux);
  endproperty
  a_ana_open_drain: assert property (p_ana_open_drain)
    else $error("open drain lock output wrong");

  property p_ana_push_pull;
    @(posedge ref_clk) disable iff (!rst_n) test_output_select == 4'h9 |=>
      !test_lock_oe_n && test_lock_out == $past(lock_ana_main & lock_ana_aux);
  endproperty
  a_ana_push_pull: assert property (p_ana_push_pull)
    else $error("push-pull analog lock wrong on test pin");

  property p_div_halved;
    @(posedge ref_clk) disable iff (!rst_n) test_output_select == 4'hF |=>
      !test_lock_oe_n && test_lock_out == $past(half_vec[3]);
  endproperty
  a_div_halved: assert property (p_div_halved)
    else $error("halved divider output wrong on test pin");

  // reference buffer; one flop of delay on a synchronous copy
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reference_out  <= 1'b0;
      reference_oe_n <= 1'b1;
    end else begin
      reference_out  <= lock_mux_modulator_control[sacw_pkg::RBUF_BIT] & reference_input;
      reference_oe_n <= ~lock_mux_modulator_control[sacw_pkg::RBUF_BIT];
    end
  end

  property p_ref_release;
    @(posedge ref_clk) disable iff (!rst_n)
      !lock_mux_modulator_control[sacw_pkg::RBUF_BIT] |=> reference_oe_n && !reference_out;
  endproperty
  a_ref_release: assert property (p_ref_release)
    else $error("reference pin driven while buffer disabled");

  // control fields decoded from the latched word
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      aux_presc_16       <= 1'b1;
      main_pump_polarity <= 1'b1;
      aux_pump_polarity  <= 1'b1;
      ref_doubler_enable <= 1'b0;
      modulator_order    <= sacw_pkg::MORD_THIRD;
      modulator_enable   <= 1'b1;
      dither_select      <= 2'h2;
    end else begin
      aux_presc_16       <= lock_mux_modulator_control[sacw_pkg::PRESC_BIT];
      main_pump_polarity <= lock_mux_modulator_control[sacw_pkg::MPOL_BIT];
      aux_pump_polarity  <= lock_mux_modulator_control[sacw_pkg::APOL_BIT];
      // doubler to main reference counter only
      ref_doubler_enable <= lock_mux_modulator_control[sacw_pkg::DBL_BIT];
      modulator_order    <= lock_mux_modulator_control[sacw_pkg::MORD_LSB +: 2];
      // code 1 switches the modulator off
      modulator_enable   <= lock_mux_modulator_control[sacw_pkg::MORD_LSB +: 2] != sacw_pkg::MORD_OFF;
      // reserved dither code falls back to none
      if (lock_mux_modulator_control[sacw_pkg::DITHER_LSB +: 2] == 2'h3) begin
        dither_select <= 2'h0;
      end else begin
        dither_select <= lock_mux_modulator_control[sacw_pkg::DITHER_LSB +: 2];
      end
    end
  end

  property p_mod_off;
    @(posedge ref_clk) disable iff (!rst_n)
      lock_mux_modulator_control[sacw_pkg::MORD_LSB +: 2] == sacw_pkg::MORD_OFF |=> !modulator_enable;
  endproperty
  a_mod_off: assert property (p_mod_off)
    else $error("modulator running with order code one");

  property p_dither_legal;
    @(posedge ref_clk) disable iff (!rst_n) dither_select != 2'h3;
  endproperty
  a_dither_legal: assert property (p_dither_legal)
    else $error("reserved dither code passed on");

  // fraction assembly
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fraction_numerator   <= 22'h00_0000;
      fraction_denominator <= 22'h00_0000;
      ext_fraction_mode    <= 1'b0;
    end else begin
      ext_fraction_mode <= ext_access;
      if (ext_access) begin
        // ten upper bits over the twelve low bits
        fraction_numerator   <= {fraction_extension_word[sacw_pkg::EXT_NUM_LSB +: 10], frac_num_low};
        fraction_denominator <= {fraction_extension_word[sacw_pkg::EXT_DEN_LSB +: 10], frac_den_low};
      end else begin
        // upper bits ignored in 12-bit mode
        fraction_numerator   <= {10'h000, frac_num_low};
        fraction_denominator <= {10'h000, frac_den_low};
      end
    end
  end

  property p_frac_narrow;
    @(posedge ref_clk) disable iff (!rst_n)
      !ext_access |=> fraction_numerator[21:12] == 10'h000 && fraction_denominator[21:12] == 10'h000;
  endproperty
  a_frac_narrow: assert property (p_frac_narrow)
    else $error("upper fraction bits used in narrow mode");

  property p_frac_wide;
    @(posedge ref_clk) disable iff (!rst_n) ext_access |=>
      fraction_numerator == {$past(fraction_extension_word[sacw_pkg::EXT_NUM_LSB +: 10]), $past(frac_num_low)};
  endproperty
  a_frac_wide: assert property (p_frac_wide)
    else $error("wide numerator not joined from both parts");

  property p_ext_default;
    @(posedge ref_clk) disable iff (!rst_n) !ext_access |=> fraction_extension_word[23:4] == 20'h0_0000;
  endproperty
  a_ext_default: assert property (p_ext_default)
    else $error("extension word not at default while access clear");

endmodule

// ===== tb/sacw_host_model.sv
`timescale 1ns/10ps
// host controller model that hands whole serial words to the block
module sacw_host_model (
  input  wire logic   ref_clk,   // system clock
  output logic [23:0] word_data, // completed serial word
  output logic        word_done  // one-cycle transfer complete pulse
);
  // idle bus before the first word
  initial begin
    word_data = 24'h00_0000;
    word_done = 1'b0;
  end
  // whole serial words sent by host
  // bus is inverted once released so a stale word can never pass as valid
  task automatic send(input logic [23:0] w);
    @(negedge ref_clk);
    word_data = w;
    word_done = 1'b1;
    @(negedge ref_clk);
    word_done = 1'b0;
    word_data = ~w;
  endtask
endmodule

// ===== tb/synth_aux_config_words_tb.sv
`timescale 1ns/10ps
// self-checking bench for the auxiliary configuration words
module synth_aux_config_words_tb;
  logic        ref_clk = 1'b0, rst_n = 1'b0, chip_enable = 1'b0, reference_input = 1'b0;
  logic        pd_main_write = 1'b0, pd_main_value = 1'b0, pd_aux_value = 1'b0;
  logic [11:0] frac_num_low = 12'h0, frac_den_low = 12'h0;
  logic [3:0]  lk = 4'h0, dp = 4'h0;
  logic [23:0] word_data, w, t, lw = sacw_pkg::LMUX_RESET;
  logic        word_done, tl_out, tl_oe_n, r_out, r_oe_n, presc, mpol, apol, dbl, men, pdm, pda, extm;
  logic [1:0]  mord, dsel;
  logic [21:0] num, den, e;
  logic [9:0]  xn = 10'h0, xd = 10'h0;
  logic        e_pdm = 1'b1, e_pda = 1'b1, e_ext = 1'b0;
  logic [21:0] exp_q[$];
  int          kind_q[$];
  int          bad_count = 0, cmp_count = 0, cyc = 0, k, c;
  sacw_host_model u_host (.ref_clk(ref_clk), .word_data(word_data), .word_done(word_done));
  sacw_config_words u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .word_data(word_data), .word_done(word_done),
    .chip_enable(chip_enable), .pd_main_write(pd_main_write), .pd_main_value(pd_main_value),
    .pd_aux_value(pd_aux_value), .frac_num_low(frac_num_low), .frac_den_low(frac_den_low),
    .lock_dig_main(lk[0]), .lock_dig_aux(lk[1]), .lock_ana_main(lk[2]), .lock_ana_aux(lk[3]),
    .aux_ref_div_pulse(dp[0]), .aux_fb_div_pulse(dp[1]), .main_ref_div_pulse(dp[2]),
    .main_fb_div_pulse(dp[3]), .reference_input(reference_input), .test_lock_out(tl_out),
    .test_lock_oe_n(tl_oe_n), .reference_out(r_out), .reference_oe_n(r_oe_n), .aux_presc_16(presc),
    .main_pump_polarity(mpol), .aux_pump_polarity(apol), .ref_doubler_enable(dbl), .modulator_enable(men),
    .modulator_order(mord), .dither_select(dsel), .main_loop_power_down(pdm), .aux_loop_power_down(pda),
    .fraction_numerator(num), .fraction_denominator(den), .ext_fraction_mode(extm));
  // clock and random divider pulses driven off the falling edge
  always #25 ref_clk = ~ref_clk;
  always @(negedge ref_clk) dp <= 4'($urandom);
  // observed value for each kind of note
  function automatic logic [21:0] got(input int kd);
    case (kd)
      0: got = {9'h0, presc, mpol, apol, dbl, men, mord, dsel, pdm, pda, extm, r_oe_n};
      1: got = {20'h0, tl_out, tl_oe_n};
      2: got = {21'h0, tl_oe_n};
      3: got = num;
      4: got = den;
      default: got = {21'h0, r_out};
    endcase
  endfunction
  // expected decoded word; reserved dither reads as none
  function automatic logic [21:0] ecfg();
    logic [1:0] dx;
    dx = (lw[17:16] == 2'h3) ? 2'h0 : lw[17:16];
    ecfg = {9'h0, lw[8], lw[9], lw[10], lw[12], lw[15:14] != 2'h1, lw[15:14], dx, e_pdm, e_pda, e_ext, ~lw[11]};
  endfunction
  task automatic note(input int kd, input logic [21:0] v);
    kind_q.push_back(kd);
    exp_q.push_back(v);
  endtask
  // watcher compares the oldest notes once outputs have settled
  always @(posedge ref_clk) begin
    #5;
    while (kind_q.size() > 0) begin
      k = kind_q.pop_front();
      e = exp_q.pop_front();
      cmp_count++;
      if (got(k) !== e) begin
        bad_count++;
        $display("wrong value at %0t: kind %0d got %h expected %h", $time, k, got(k), e);
      end
    end
  end
  // wait for pins, then note every expectation; inputs hold one more edge
  task automatic fin();
    logic o;
    repeat (3) @(negedge ref_clk);
    note(0, ecfg());
    c = int'(lw[7:4]);
    o = (c == 1) | (c == 3 & lk[0] & lk[1]) | (c == 4 & lk[0]) | (c == 5 & lk[1]) |
        ((c == 6 | c == 9) & lk[2] & lk[3]) | ((c == 7 | c == 10) & lk[2]) | ((c == 8 | c == 11) & lk[3]);
    if (c == 0) note(2, 22'h1);
    else if (c > 11) note(2, 22'h0);
    else if (c > 5 && c < 9) note(1, {20'h0, 1'b0, o});
    else note(1, {20'h0, o, 1'b0});
    note(5, {21'h0, reference_input & lw[11]});
    note(3, {e_ext ? xn : 10'h0, frac_num_low});
    note(4, {e_ext ? xd : 10'h0, frac_den_low});
    @(negedge ref_clk);
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard, far above the roughly 190 cycles the run needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(70));
    // denominator kept at or above 1000
    frac_num_low = 12'($urandom);
    frac_den_low = 12'h3E9;
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    fin();
    // every selector code with all modulator orders and dither codes
    for (int i = 0; i < 16; i++) begin
      w = 24'($urandom);
      w[23:12] = {4'h2, 2'h0, i[3:2], i[1:0], 1'b0, w[12]};
      w[7:0] = {i[3:0], sacw_pkg::ADDR_LMUX};
      lk = 4'($urandom);
      reference_input = 1'($urandom);
      u_host.send(w);
      lw = w;
      fin();
    end
    // auto power-up against chip enable
    pd_main_value = 1'b1;
    pd_aux_value = 1'b1;
    for (int i = 0; i < 4; i++) begin
      chip_enable = i[0];
      lw[23] = i[1];
      u_host.send(lw);
      @(negedge ref_clk) pd_main_write = 1'b1;
      @(negedge ref_clk) pd_main_write = 1'b0;
      w = 24'($urandom);
      w[3:0] = sacw_pkg::ADDR_MAIN;
      u_host.send(w);
      e_pdm = !(i[0] && i[1]);
      e_pda = e_pdm;
      fin();
    end
    // extension word refused, accepted, then forced back to default
    w = 24'($urandom);
    w[3:0] = sacw_pkg::ADDR_FEXT;
    u_host.send(w);
    fin();
    t = 24'($urandom);
    t[3:0] = sacw_pkg::ADDR_THIRD;
    t[21] = 1'b1;
    u_host.send(t);
    e_ext = 1'b1;
    fin();
    u_host.send(w);
    {xn, xd} = {w[13:4], w[23:14]};
    fin();
    // numerator below 4096 sent with zero upper bits
    w[13:4] = 10'h000;
    u_host.send(w);
    xn = 10'h000;
    fin();
    t[21] = 1'b0;
    u_host.send(t);
    {e_ext, xn, xd} = 21'h0;
    fin();
    t[21] = 1'b1;
    u_host.send(t);
    e_ext = 1'b1;
    fin();
    // mid-run reset brings back default words and powered-down loops
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    {lw, e_pdm, e_pda, e_ext} = {sacw_pkg::LMUX_RESET, 3'h6};
    fin();
    wrap_up();
  end
endmodule
